// ==== shared/rfb_pkg.sv ====
/*
  Shared constants and types of the radio frame buffer: buffer geometry,
  processor address window, radio-side states and commands.
  Assumes one 100 MHz clock and a synchronous active-high reset everywhere.
*/
package rfb_pkg;
  // ============================================================
  // Geometry
  localparam int          RFB_DEPTH      = 128;
  localparam int          RFB_AW         = 7;
  localparam logic [8:0]  RFB_BASE_ADDR  = 9'h180;
  localparam logic [8:0]  RFB_LAST_ADDR  = 9'h1FF;
  localparam logic [6:0]  RFB_PHR_INDEX  = 7'h00;
  localparam logic [7:0]  RFB_MIN_LEN    = 8'h02;
  localparam logic [7:0]  RFB_MAX_LEN    = 8'h80;
  localparam logic [7:0]  RFB_FCS_BYTES  = 8'h02;
  localparam logic [7:0]  RFB_RESET_BYTE = 8'h00;
  localparam logic [7:0]  RFB_POISON     = 8'h00;

  // ============================================================
  // Controller register map (byte offsets on the software port)
  localparam logic [8:0]  RFB_CTRL_ADDR   = 9'h000;
  localparam logic [8:0]  RFB_STATUS_ADDR = 9'h001;
  localparam logic [8:0]  RFB_CMD_ADDR    = 9'h002;
  localparam logic [8:0]  RFB_RXLEN_ADDR  = 9'h003;
  // Control bit positions
  localparam int          RFB_CTRL_AUTO_FCS  = 0;
  localparam int          RFB_CTRL_SAFE_MODE = 1;
  localparam int          RFB_CTRL_PWR_RED   = 2;
  localparam int          RFB_CTRL_TRIGGER   = 3;
  localparam logic [7:0]  RFB_CTRL_RESET     = 8'h00;

  // ============================================================
  // Radio states and commands
  typedef enum logic [2:0] {
    RFB_ST_OFF     = 3'b000,
    RFB_ST_SYNTH   = 3'b001,
    RFB_ST_RX_ON   = 3'b010,
    RFB_ST_BUSY_RX = 3'b011,
    RFB_ST_RETRY   = 3'b100,
    RFB_ST_BUSY_TX = 3'b101,
    RFB_ST_SLEEP   = 3'b110,
    RFB_ST_ACK_RX  = 3'b111
  } rfb_state_type;

  typedef enum logic [2:0] {
    RFB_CMD_NOP      = 3'b000,
    RFB_CMD_TX_START = 3'b001,
    RFB_CMD_OFF      = 3'b010,
    RFB_CMD_SYNTH_ON = 3'b011,
    RFB_CMD_RX_ON    = 3'b100,
    RFB_CMD_RETRY_ON = 3'b101,
    RFB_CMD_SLEEP    = 3'b110,
    RFB_CMD_RESET    = 3'b111
  } rfb_cmd_type;
endpackage : rfb_pkg

// ==== shared/rfb_if.sv ====
/*
  Link between the frame buffer device and its controller: processor-side
  buffer port plus the radio control and status lines.
  Assumes both ends run on the same clock; no clocking block.
*/
interface rfb_if;
  import rfb_pkg::*;
  // Processor buffer port
  logic [8:0]    io_addr;
  logic [7:0]    io_wdata;
  logic          io_wr;
  logic          io_rd;
  logic [7:0]    io_rdata;
  logic          io_ok;
  // Radio control from the controller
  rfb_cmd_type   state_command_field;
  logic          sleep_trigger_bit;
  logic          radio_reset_bit;
  logic          radio_power_reduce_bit;
  logic          auto_fcs_en;
  logic          rx_safe_mode;
  // Status back from the device
  rfb_state_type radio_state_reg;
  logic [7:0]    received_length_reg;
  logic          receive_done_irq;
  logic          tx_done;

  modport device (
    input  io_addr, io_wdata, io_wr, io_rd, state_command_field, sleep_trigger_bit,
    input  radio_reset_bit, radio_power_reduce_bit, auto_fcs_en, rx_safe_mode,
    output io_rdata, io_ok, radio_state_reg, received_length_reg, receive_done_irq, tx_done
  );
  modport ctrl (
    output io_addr, io_wdata, io_wr, io_rd, state_command_field, sleep_trigger_bit,
    output radio_reset_bit, radio_power_reduce_bit, auto_fcs_en, rx_safe_mode,
    input  io_rdata, io_ok, radio_state_reg, received_length_reg, receive_done_irq, tx_done
  );
endinterface : rfb_if

// ==== core/rfb_device.sv ====
/*
  Frame buffer of the radio: 128-byte two-port store, processor port on the
  link, radio receive/transmit engine port on the user side.
  Assumes the radio engine is ready for a byte every cycle it is offered.
*/
// The strobed register port and the register addresses are this design's own decisions.
module rfb_device
  import rfb_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       srst_in,
  // Link to the controller
  rfb_if.device           lnk,
  // Receive engine: payload bytes after the sync header
  input  wire logic       rx_start_in,
  input  wire logic [7:0] rx_len_in,
  input  wire logic       rx_valid_in,
  input  wire logic [7:0] rx_data_in,
  input  wire logic       rx_end_in,
  input  wire logic       rx_fcs_ok_in,
  input  wire logic [7:0] rx_lqi_in,
  // Transmit engine
  output logic            tx_valid_out,
  output logic [7:0]      tx_data_out,
  output logic            tx_fcs_slot_out,
  output logic            tx_last_out,
  // Acknowledge result during retry wait
  input  wire logic       ack_seen_in
);
  // ============================================================
  // Storage and state
  logic [7:0]    mem [RFB_DEPTH];
  rfb_state_type state;
  logic [RFB_AW-1:0] rptr;
  logic [RFB_AW-1:0] wptr;
  logic [7:0]    tx_len;
  logic [7:0]    tx_cnt;
  logic          guarded;
  logic          trig_q;
  logic [7:0]    io_rdata;
  logic          io_ok;
  logic [7:0]    rx_len;
  logic          rx_done;
  logic          tx_done;

  // ============================================================
  // Decode
  wire           in_window  = lnk.io_addr >= RFB_BASE_ADDR && lnk.io_addr <= RFB_LAST_ADDR;
  wire           awake      = !lnk.radio_power_reduce_bit && state != RFB_ST_SLEEP;
  wire           cpu_wr     = lnk.io_wr && in_window && awake;
  wire           cpu_rd     = lnk.io_rd && in_window && awake;
  wire [RFB_AW-1:0] cpu_idx = lnk.io_addr[RFB_AW-1:0];
  wire           wipe       = srst_in || lnk.radio_reset_bit || lnk.radio_power_reduce_bit
                              || state == RFB_ST_SLEEP;
  wire           trig_rise  = lnk.sleep_trigger_bit && !trig_q;
  wire           tx_go      = (state == RFB_ST_SYNTH || state == RFB_ST_RETRY)
                              && (trig_rise || lnk.state_command_field == RFB_CMD_TX_START);
  // Radio writes only in a receive-busy state, never while guarded
  wire           rx_store   = state == RFB_ST_BUSY_RX && !guarded;
  wire           rx_wr      = rx_store && rx_valid_in;
  wire           lqi_wr     = rx_store && rx_end_in;
  wire           radio_wr   = (rx_wr || lqi_wr) && !(cpu_wr && cpu_idx == wptr);
  wire [7:0]     radio_byte = rx_wr ? rx_data_in : rx_lqi_in;
  wire           fcs_slot   = lnk.auto_fcs_en && tx_cnt + RFB_FCS_BYTES > tx_len;
  wire           len_ok     = mem[RFB_PHR_INDEX] >= RFB_MIN_LEN
                              && mem[RFB_PHR_INDEX] <= RFB_MAX_LEN;
  wire           tx_active  = state == RFB_ST_BUSY_TX;
  wire           tx_final   = tx_active && tx_cnt == tx_len;

  // ============================================================
  // Memory ports
  always_ff @(posedge sys_clk_in) begin
    if (cpu_wr) begin
      mem[cpu_idx] <= lnk.io_wdata;
    end
    if (radio_wr) begin
      mem[wptr] <= radio_byte;
    end
  end

  // ============================================================
  // Radio state machine
  always_ff @(posedge sys_clk_in) begin
    if (srst_in || lnk.radio_reset_bit) begin
      state <= RFB_ST_OFF;
    end else if (lnk.state_command_field == RFB_CMD_SLEEP) begin
      state <= RFB_ST_SLEEP;
    end else begin
      unique case (state)
        RFB_ST_OFF, RFB_ST_SLEEP: begin
          if (lnk.state_command_field == RFB_CMD_SYNTH_ON) state <= RFB_ST_SYNTH;
          else if (lnk.state_command_field == RFB_CMD_RX_ON) state <= RFB_ST_RX_ON;
          else if (lnk.state_command_field == RFB_CMD_RETRY_ON) state <= RFB_ST_RETRY;
        end
        RFB_ST_SYNTH, RFB_ST_RETRY: begin
          if (tx_go && len_ok) state <= RFB_ST_BUSY_TX;
          else if (lnk.state_command_field == RFB_CMD_RX_ON) state <= RFB_ST_RX_ON;
          else if (lnk.state_command_field == RFB_CMD_SYNTH_ON) state <= RFB_ST_SYNTH;
          else if (lnk.state_command_field == RFB_CMD_RETRY_ON) state <= RFB_ST_RETRY;
          else if (lnk.state_command_field == RFB_CMD_OFF) state <= RFB_ST_OFF;
        end
        RFB_ST_RX_ON: begin
          if (rx_start_in) state <= RFB_ST_BUSY_RX;
          else if (lnk.state_command_field == RFB_CMD_SYNTH_ON) state <= RFB_ST_SYNTH;
          else if (lnk.state_command_field == RFB_CMD_OFF) state <= RFB_ST_OFF;
        end
        RFB_ST_BUSY_RX: begin
          if (rx_end_in) state <= RFB_ST_RX_ON;
        end
        RFB_ST_BUSY_TX: begin
          if (tx_final) state <= lnk.state_command_field == RFB_CMD_RETRY_ON || trig_q
                                 ? RFB_ST_ACK_RX : RFB_ST_SYNTH;
        end
        RFB_ST_ACK_RX: begin
          // Frames here are only checked, the pending frame stays put
          if (ack_seen_in || rx_end_in) state <= RFB_ST_RETRY;
        end
      endcase
    end
  end

  // ============================================================
  // Pointers, guard and status
  always_ff @(posedge sys_clk_in) begin
    if (wipe) begin
      wptr     <= '0;
      rptr     <= '0;
      tx_len   <= RFB_RESET_BYTE;
      tx_cnt   <= RFB_RESET_BYTE;
      guarded  <= 1'b0;
      trig_q   <= 1'b0;
      io_rdata <= RFB_POISON;
      io_ok    <= 1'b0;
      rx_len   <= RFB_RESET_BYTE;
      rx_done  <= 1'b0;
      tx_done  <= 1'b0;
    end else begin
      trig_q   <= lnk.sleep_trigger_bit;
      io_ok    <= cpu_rd || cpu_wr;
      io_rdata <= cpu_rd ? mem[cpu_idx] : RFB_POISON;
      rx_done  <= lqi_wr;
      tx_done  <= tx_final;
      if (state == RFB_ST_RX_ON && rx_start_in && !guarded) begin
        wptr   <= '0;
        rx_len <= rx_len_in;
      end else if (rx_wr) begin
        wptr   <= wptr + 1'b1;
      end
      if (lqi_wr && lnk.rx_safe_mode && rx_fcs_ok_in) guarded <= 1'b1;
      else if (!lnk.rx_safe_mode) guarded <= 1'b0;
      if (tx_go && len_ok) begin
        tx_len <= mem[RFB_PHR_INDEX];
        tx_cnt <= 8'h00;
        rptr   <= RFB_PHR_INDEX;
      end else if (tx_active) begin
        tx_cnt <= tx_cnt + 8'h01;
        rptr   <= rptr + 1'b1;
      end
    end
  end

  // ============================================================
  // Transmit byte stream: length byte then payload
  always_ff @(posedge sys_clk_in) begin
    if (wipe) begin
      tx_valid_out    <= 1'b0;
      tx_data_out     <= RFB_RESET_BYTE;
      tx_fcs_slot_out <= 1'b0;
      tx_last_out     <= 1'b0;
    end else begin
      tx_valid_out    <= tx_active;
      tx_data_out     <= tx_active ? mem[rptr] : RFB_RESET_BYTE;
      tx_fcs_slot_out <= tx_active && tx_cnt != 8'h00 && fcs_slot;
      tx_last_out     <= tx_final;
    end
  end

  assign lnk.io_rdata            = io_rdata;
  assign lnk.io_ok               = io_ok;
  assign lnk.radio_state_reg     = state;
  assign lnk.received_length_reg = rx_len;
  assign lnk.receive_done_irq    = rx_done;
  assign lnk.tx_done             = tx_done;
endmodule : rfb_device

// ==== core/rfb_ctrl.sv ====
/*
  Controller end: software-facing registers that drive the frame buffer link.
  Assumes a plain register port with read data one cycle after the strobe.
*/
module rfb_ctrl
  import rfb_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       srst_in,
  // Software register port
  input  wire logic [8:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic [7:0]      rdata_out,
  // Link to the device
  rfb_if.ctrl             lnk
);
  // ============================================================
  // Registers
  logic [7:0]  ctrl;
  rfb_cmd_type cmd;
  logic        buf_rd_q;
  logic [7:0]  reg_rd;

  wire         buf_hit  = addr_in >= RFB_BASE_ADDR && addr_in <= RFB_LAST_ADDR;
  wire         ctrl_hit = addr_in == RFB_CTRL_ADDR;
  wire         cmd_hit  = addr_in == RFB_CMD_ADDR;
  wire [7:0]   status   = {3'b000, lnk.tx_done, lnk.receive_done_irq, lnk.radio_state_reg};
  wire [7:0]   reg_val  = ctrl_hit ? ctrl
                        : cmd_hit ? {5'b00000, cmd}
                        : addr_in == RFB_STATUS_ADDR ? status
                        : addr_in == RFB_RXLEN_ADDR ? lnk.received_length_reg : 8'h00;

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      ctrl     <= RFB_CTRL_RESET;
      cmd      <= RFB_CMD_NOP;
      buf_rd_q <= 1'b0;
      reg_rd   <= 8'h00;
    end else begin
      // Buffer accesses pass straight through so read data keep one-cycle timing
      buf_rd_q <= rd_in && buf_hit;
      reg_rd   <= rd_in ? reg_val : 8'h00;
      cmd      <= wr_in && cmd_hit ? rfb_cmd_type'(wdata_in[2:0]) : RFB_CMD_NOP;
      if (wr_in && ctrl_hit) ctrl <= wdata_in;
    end
  end

  assign rdata_out                  = buf_rd_q ? lnk.io_rdata : reg_rd;
  assign lnk.io_addr                = addr_in;
  assign lnk.io_wdata               = wdata_in;
  assign lnk.io_wr                  = wr_in && buf_hit;
  assign lnk.io_rd                  = rd_in && buf_hit;
  assign lnk.state_command_field    = cmd == RFB_CMD_RESET ? RFB_CMD_NOP : cmd;
  assign lnk.radio_reset_bit        = cmd == RFB_CMD_RESET;
  assign lnk.sleep_trigger_bit      = ctrl[RFB_CTRL_TRIGGER];
  assign lnk.radio_power_reduce_bit = ctrl[RFB_CTRL_PWR_RED];
  assign lnk.auto_fcs_en            = ctrl[RFB_CTRL_AUTO_FCS];
  assign lnk.rx_safe_mode           = ctrl[RFB_CTRL_SAFE_MODE];
endmodule : rfb_ctrl

// ==== tb/rfb_checker_sva.sv ====
/*
  Checker on the link between controller and frame buffer device.
  Assumes one clock domain and the synchronous active-high reset.
*/
module rfb_checker_sva
  import rfb_pkg::*;
(
  // Clock and reset
  input wire logic          sys_clk_in,
  input wire logic          srst_in,
  // Link signals
  input wire logic [8:0]    io_addr,
  input wire logic [7:0]    io_wdata,
  input wire logic          io_wr,
  input wire logic          io_rd,
  input wire logic [7:0]    io_rdata,
  input wire logic          io_ok,
  input wire logic          radio_power_reduce_bit,
  input wire rfb_cmd_type   state_command_field,
  input wire rfb_state_type radio_state_reg,
  input wire logic [7:0]    received_length_reg,
  input wire logic          receive_done_irq,
  input wire logic          tx_done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  // ==========================================================
  // Helpers
  wire in_win = io_addr[8:7] == 2'b11;
  wire awake  = !radio_power_reduce_bit && radio_state_reg != RFB_ST_SLEEP;
  wire quiet  = awake && radio_state_reg != RFB_ST_BUSY_RX;
  // Radio writes excluded, so a read must return the previous write
  sequence s_wr_rd;
    io_wr && in_win && quiet ##1 quiet ##1 io_rd && $stable(io_addr) && quiet;
  endsequence
  // ==========================================================
  // Assertions
  AST_OK_WIN: assert property ((io_rd || io_wr) && in_win && awake |=> io_ok)
    else $error("window access not accepted");
  AST_NO_WIN: assert property ((io_rd || io_wr) && !in_win |=> !io_ok)
    else $error("access outside window accepted");
  AST_PWR: assert property ((io_rd || io_wr) && radio_power_reduce_bit |=> !io_ok && io_rdata == 8'h00)
    else $error("access while powered down");
  AST_SLEEP_REFUSE: assert property (io_rd && radio_state_reg == RFB_ST_SLEEP |=> !io_ok)
    else $error("access while asleep");
  AST_OK_CAUSE: assert property (io_ok |-> $past(io_rd) || $past(io_wr))
    else $error("ok without request");
  AST_READBACK: assert property (s_wr_rd |=> io_ok && io_rdata == $past(io_wdata, 3))
    else $error("read does not return written byte");
  AST_RX_DONE: assert property (receive_done_irq |-> radio_state_reg == RFB_ST_RX_ON)
    else $error("receive done outside rx on");
  AST_TX_START: assert property ($rose(radio_state_reg == RFB_ST_BUSY_TX)
    |-> $past(radio_state_reg) inside {RFB_ST_SYNTH, RFB_ST_RETRY})
    else $error("transmit from wrong state");
  AST_TX_DONE: assert property (tx_done |-> $past(radio_state_reg) == RFB_ST_BUSY_TX
    || $past(radio_state_reg, 2) == RFB_ST_BUSY_TX)
    else $error("tx done without transmit");
  AST_SLEEP_CMD: assert property (state_command_field == RFB_CMD_SLEEP |=> ##[0:2] radio_state_reg == RFB_ST_SLEEP)
    else $error("sleep command ignored");
  AST_RXLEN: assert property (!$stable(received_length_reg)
    |-> radio_state_reg inside {RFB_ST_BUSY_RX, RFB_ST_SLEEP, RFB_ST_OFF})
    else $error("length changed outside reception");
endmodule : rfb_checker_sva

// ==== tb/testbench.sv ====
/*
  Bench: controller and device joined by the link; drives the software
  port and the radio engine side. Assumes one 100 MHz clock.
*/
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin error_cnt++; \
  $display("[ERR] %0t got %0h exp %0h", $time, got, exp); end end
module testbench
  import rfb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       sys_clk_in = 1'b0;
  logic       srst_in    = 1'b1;
  logic [8:0] addr_in    = 9'h000;
  logic [7:0] wdata_in   = 8'h00;
  logic       wr_in      = 1'b0;
  logic       rd_in      = 1'b0;
  logic [7:0] rdata_out;
  logic       rx_start_in = 1'b0, rx_valid_in = 1'b0, rx_end_in = 1'b0, rx_fcs_ok_in = 1'b1;
  logic [7:0] rx_len_in = 8'h00, rx_data_in = 8'h00, rx_lqi_in = 8'h00;
  logic       tx_valid_out, tx_fcs_slot_out, tx_last_out;
  logic [7:0] tx_data_out, v;
  int         error_cnt = 0;
  int         compares  = 0;
  rfb_if lnk_if ();
  // ==========================================================
  // Design and checker
  rfb_ctrl rfb_ctrl_inst (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .lnk(lnk_if));
  rfb_device rfb_device_inst (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .lnk(lnk_if),
    .rx_start_in(rx_start_in), .rx_len_in(rx_len_in), .rx_valid_in(rx_valid_in), .rx_data_in(rx_data_in),
    .rx_end_in(rx_end_in), .rx_fcs_ok_in(rx_fcs_ok_in), .rx_lqi_in(rx_lqi_in), .tx_valid_out(tx_valid_out),
    .tx_data_out(tx_data_out), .tx_fcs_slot_out(tx_fcs_slot_out), .tx_last_out(tx_last_out), .ack_seen_in(1'b0));
  rfb_checker_sva rfb_checker_sva_inst (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
    .io_addr(lnk_if.io_addr), .io_wdata(lnk_if.io_wdata), .io_wr(lnk_if.io_wr), .io_rd(lnk_if.io_rd),
    .io_rdata(lnk_if.io_rdata), .io_ok(lnk_if.io_ok), .radio_power_reduce_bit(lnk_if.radio_power_reduce_bit),
    .state_command_field(lnk_if.state_command_field), .radio_state_reg(lnk_if.radio_state_reg),
    .received_length_reg(lnk_if.received_length_reg), .receive_done_irq(lnk_if.receive_done_irq),
    .tx_done(lnk_if.tx_done));
  always #5 sys_clk_in = ~sys_clk_in;
  // ==========================================================
  // Software port; every task starts and ends just after an edge
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    wr_in <= 1'b1; addr_in <= a; wdata_in <= d;
    @(posedge sys_clk_in); wr_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask : wr
  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    rd_in <= 1'b1; addr_in <= a;
    @(posedge sys_clk_in); rd_in <= 1'b0;
    #1 d = rdata_out;
    @(posedge sys_clk_in);
  endtask : rd
  task automatic cmd(input rfb_cmd_type c);
    wr(RFB_CMD_ADDR, {5'h00, c});
    repeat (3) @(posedge sys_clk_in);
  endtask : cmd
  // ==========================================================
  // Scenarios
  task automatic t_buffer;
    rd(RFB_CTRL_ADDR, v); `CHK(v, RFB_CTRL_RESET)
    rd(9'h004, v); `CHK(v, 8'h00)
    wr(9'h180, 8'hA5); rd(9'h180, v); `CHK(v, 8'hA5)
    wr(9'h1FF, 8'h5A); rd(9'h1FF, v); `CHK(v, 8'h5A)
    rd(9'h180, v); `CHK(v, 8'hA5)
  endtask : t_buffer
  task automatic t_power;
    wr(RFB_CTRL_ADDR, 8'h04); repeat (2) @(posedge sys_clk_in);
    rd(9'h180, v); `CHK(v, 8'h00)
    wr(RFB_CTRL_ADDR, 8'h00); repeat (2) @(posedge sys_clk_in);
  endtask : t_power
  task automatic t_rx;
    cmd(RFB_CMD_RX_ON);
    rd(RFB_STATUS_ADDR, v); `CHK(v[2:0], RFB_ST_RX_ON)
    rx_start_in <= 1'b1; rx_len_in <= 8'h03;
    @(posedge sys_clk_in); rx_start_in <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      rx_valid_in <= 1'b1; rx_data_in <= 8'h11 * (i + 1);
      @(posedge sys_clk_in);
    end
    rx_valid_in <= 1'b0; rx_end_in <= 1'b1; rx_lqi_in <= 8'h77;
    @(posedge sys_clk_in); rx_end_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    rd(RFB_RXLEN_ADDR, v); `CHK(v, 8'h03)
    for (int i = 0; i < 3; i++) begin
      rd(9'h180 + 9'(i), v); `CHK(v, 8'(8'h11 * (i + 1)))
    end
    rd(9'h183, v); `CHK(v, 8'h77)
    cmd(RFB_CMD_SYNTH_ON);
    rd(RFB_STATUS_ADDR, v); `CHK(v[2:0], RFB_ST_SYNTH)
  endtask : t_rx
  task automatic t_tx;
    logic [7:0] q[$];
    int         f;
    wr(9'h180, 8'h03); wr(9'h181, 8'hC1); wr(9'h182, 8'hC2); wr(9'h183, 8'hC3);
    cmd(RFB_CMD_SYNTH_ON);
    // First pass without, second with automatic checksum
    for (int p = 0; p < 2; p++) begin
      q.delete();
      f = 0;
      wr(RFB_CTRL_ADDR, (p != 0) ? 8'h01 : 8'h00);
      wr(RFB_CMD_ADDR, {5'h00, RFB_CMD_TX_START});
      for (int n = 0; n < 60; n++) begin
        @(posedge sys_clk_in); #1;
        if (tx_valid_out === 1'b1) q.push_back(tx_data_out);
        if (tx_fcs_slot_out === 1'b1) f++;
        if (tx_last_out === 1'b1) break;
      end
      @(posedge sys_clk_in);
      `CHK(q.size(), 4)
      if (q.size() == 4) begin
        `CHK(q[0], 8'h03)
        `CHK(q[3], 8'hC3)
      end
      `CHK(f, (p != 0) ? 2 : 0)
      repeat (4) @(posedge sys_clk_in);
      rd(RFB_STATUS_ADDR, v); `CHK(v[2:0], RFB_ST_SYNTH)
    end
    wr(RFB_CTRL_ADDR, 8'h00);
  endtask : t_tx
  task automatic t_sleep;
    cmd(RFB_CMD_SLEEP);
    rd(RFB_STATUS_ADDR, v); `CHK(v[2:0], RFB_ST_SLEEP)
    rd(9'h180, v); `CHK(v, 8'h00)
  endtask : t_sleep
  // ==========================================================
  // Verdict and sequencing
  task automatic end_of_test;
    if (error_cnt == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (8) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    @(posedge sys_clk_in);
    t_buffer(); t_power(); t_rx(); t_tx(); t_sleep();
    end_of_test();
  end
  // Whole run needs well under 1000 cycles
  initial begin
    repeat (5000) @(posedge sys_clk_in);
    error_cnt++;
    end_of_test();
  end
endmodule : testbench
